// ===== src/tacf_map.svh
// Register offsets, field positions and reset values of the access-control field block.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
`ifndef TACF_MAP_SVH
`define TACF_MAP_SVH

// ====================================================================
// Register byte offsets.
`define TACF_OFS_CTRL 8'h00
`define TACF_OFS_OWN_ADDR 8'h04
`define TACF_OFS_NEXT_ADDR 8'h08
`define TACF_OFS_CMD 8'h0c
`define TACF_OFS_FRAME_STATUS 8'h10
`define TACF_OFS_IRQ_STATUS 8'h14
`define TACF_OFS_IRQ_MASK 8'h18
`define TACF_OFS_LINK_STATE 8'h1c

// ====================================================================
// Field positions of the supervisory control byte.
`define TACF_SCB_RESCAN_BIT 7
`define TACF_SCB_WANTS_BIT 6
`define TACF_SCB_CAUSE_MSB 2

// ====================================================================
// Field positions of the software registers.
`define TACF_CTRL_JOIN_BIT 0
`define TACF_FSTAT_WANTS_BIT 3
`define TACF_LINK_MEMBER_BIT 0
`define TACF_LINK_PEND_BIT 1
`define TACF_LINK_CAUSE_LSB 4

// ====================================================================
// Event bits of the interrupt status and mask registers.
`define TACF_EV_RESCAN 0
`define TACF_EV_RESPONSE 1
`define TACF_EV_CMD_SENT 2
`define TACF_EV_COUNT 3

// ====================================================================
// Reset values and bus answers.
`define TACF_OWN_ADDR_RST 8'h00
`define TACF_NEXT_ADDR_RST 8'h00
`define TACF_RESP_OKAY 2'h0
`define TACF_RESP_SLVERR 2'h2

`endif

// ===== src/tacf_pkg.sv
// Types shared by the access-control field block.
// Assumes nothing of its surroundings.
package tacf_pkg;

  // ====================================================================
  // Outcome codes of the last received frame.
  typedef enum logic [2:0] {
    TACF_CAUSE_OK = 3'h0,
    TACF_CAUSE_NO_BUFFERS = 3'h1,
    TACF_CAUSE_RX_DISABLED = 3'h2,
    TACF_CAUSE_OVERRUN = 3'h3,
    TACF_CAUSE_OVER_16_BUFS = 3'h4
  } tacf_cause_type;

  // Transmit slot states.
  typedef enum logic [1:0] {
    TACF_TX_IDLE,
    TACF_TX_BUSY
  } tacf_tx_state_type;

  // Tells whether a three-bit code is one of the defined outcomes.
  function automatic logic tacf_cause_legal(input logic [2:0] code);
    tacf_cause_legal = (code <= 3'(TACF_CAUSE_OVER_16_BUFS));
  endfunction : tacf_cause_legal

endpackage : tacf_pkg

// ===== src/tacf_scb_build.sv
// Assembles an outgoing supervisory control byte from its fields.
// Assumes the caller registers the result before it leaves the block.
`timescale 1ns/100ps
`include "tacf_map.svh"

module tacf_scb_build (
  input wire logic rescan,
  input wire logic wants,
  input wire logic [2:0] cause,
  output logic [7:0] scb_byte
);

  // ====================================================================
  // Byte assembly; the three reserved bits always leave as zero.
  always_comb begin
    scb_byte = 8'h00; // [RL7]
    scb_byte[`TACF_SCB_RESCAN_BIT] = rescan;
    scb_byte[`TACF_SCB_WANTS_BIT] = wants;
    scb_byte[`TACF_SCB_CAUSE_MSB:0] = cause;
  end

endmodule : tacf_scb_build

// ===== src/tacf_irq.sv
// Sticky event status with write-one-to-clear, a mask and one level interrupt.
// Assumes event pulses and register strobes are synchronous to aclk.
`timescale 1ns/100ps

module tacf_irq #(
  parameter int EVENTS = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [EVENTS-1:0] event_pulse,
  input wire logic clear_wr,
  input wire logic mask_wr,
  input wire logic [EVENTS-1:0] wr_data,
  output logic [EVENTS-1:0] status,
  output logic [EVENTS-1:0] mask,
  output logic irq
);

  logic [EVENTS-1:0] next_status;
  logic [EVENTS-1:0] next_mask;

  // ====================================================================
  // A new event wins over a clear written in the same cycle.
  always_comb begin
    next_status = status;
    if (clear_wr) begin
      next_status = next_status & ~wr_data;
    end
    next_status = next_status | event_pulse;
    next_mask = mask_wr ? wr_data : mask;
  end

  // Registers the status and mask.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
      mask <= '0;
    end else begin
      status <= next_status;
      mask <= next_mask;
    end
  end

  // The interrupt stays high while any unmasked status bit is set.
  assign irq = |(status & mask);

endmodule : tacf_irq

// ===== src/tacf_top.sv
// Access-control field logic of a token-passing network node, with an AXI4-Lite slave.
// Assumes link inputs are synchronous to aclk and that the framer carries the byte on the wire.
//
// Overview of operation
// RL1: An addressed command with the rescan flag in bit 7 reloads the next node address with own address plus one.
// RL2: A response carries in bit 6 the AND of the join-ring request and the ring-membership status.
// RL3: A received response's bit 6 only goes to the host in the frame status byte and causes no action.
// RL4: A response carries in bits 2 to 0 the outcome code of the most recently received frame; an undefined code is not stored.
// RL5: Outcome codes are 000 ok, 001 no buffers, 010 receiver off, 011 overrun, 100 over 16 buffers.
// RL6: The byte goes out as a host command in transparent mode, otherwise as a response to a request.
// RL7: Bits 5 to 3 are sent as zero and ignored on receipt.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "tacf_map.svh"

module tacf_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_scb_valid,
  input wire logic [7:0] rx_scb_byte,
  input wire logic rx_scb_is_command,
  input wire logic rx_node_addressed,
  input wire logic rx_frame_done,
  input wire logic [2:0] rx_frame_outcome,
  input wire logic ack_request,
  input wire logic member_of_ring_status,
  output logic tx_scb_valid,
  input wire logic tx_scb_ready,
  output logic [7:0] tx_scb_byte,
  output logic tx_scb_is_command,
  output logic [7:0] next_node_address,
  output logic irq
);

  // ====================================================================
  // Elaboration check.
  if (ADDR_W < 5 || ADDR_W > 8) begin : gen_addr_check
    $error("tacf_top: ADDR_W must lie between 5 and 8");
  end

  // Selects the register word addressed by a byte address.
  function automatic logic [7:0] word_of(input logic [ADDR_W-1:0] addr);
    word_of = 8'(addr) & 8'hfc;
  endfunction : word_of

  // Tells whether a byte address hits a mapped register.
  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = (word_of(addr) <= `TACF_OFS_LINK_STATE);
  endfunction : mapped

  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr_q, next_aw_addr_q, wr_addr;
  logic [31:0] w_data_q, next_w_data_q, wr_data;
  logic w_lane0_q, next_w_lane0_q;
  logic next_bvalid, next_rvalid, do_write, wr_byte0;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_word;
  logic join_ring_request_ctl, next_join;
  logic [7:0] own_node_address, next_own;
  logic [7:0] next_next_addr;
  logic [7:0] cmd_byte, next_cmd_byte;
  logic cmd_pend, next_cmd_pend, resp_pend, next_resp_pend;
  logic [3:0] frame_status_byte, next_frame_status;
  logic [2:0] last_cause, next_last_cause;
  tacf_pkg::tacf_tx_state_type tx_state, next_tx_state;
  logic [7:0] next_tx_byte, build_byte;
  logic next_tx_is_cmd, load_resp, load_cmd, rescan_hit, resp_rx;
  logic [`TACF_EV_COUNT-1:0] events, irq_status, irq_mask;

  // ====================================================================
  // AXI4-Lite write channel: address and data taken in either order.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_held ? w_data_q : s_axi_wdata;
  assign do_write = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
  assign wr_byte0 = do_write && (w_held ? w_lane0_q : s_axi_wstrb[0]) && mapped(wr_addr);

  // Next state of the write channel.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr_q = aw_addr_q;
    next_w_data_q = w_data_q;
    next_w_lane0_q = w_lane0_q;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(wr_addr) ? `TACF_RESP_OKAY : `TACF_RESP_SLVERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        next_aw_held = 1'b1;
        next_aw_addr_q = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        next_w_held = 1'b1;
        next_w_data_q = s_axi_wdata;
        next_w_lane0_q = s_axi_wstrb[0];
      end
    end
  end

  // ====================================================================
  // AXI4-Lite read channel: the answer follows one cycle after the address.
  assign s_axi_arready = !s_axi_rvalid;

  // Read multiplexer; unmapped words read as zero with an error answer.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (word_of(s_axi_araddr))
      `TACF_OFS_CTRL: rd_word[`TACF_CTRL_JOIN_BIT] = join_ring_request_ctl;
      `TACF_OFS_OWN_ADDR: rd_word[7:0] = own_node_address;
      `TACF_OFS_NEXT_ADDR: rd_word[7:0] = next_node_address;
      `TACF_OFS_CMD: rd_word[7:0] = cmd_byte;
      `TACF_OFS_FRAME_STATUS: rd_word[3:0] = frame_status_byte; // [RL3]
      `TACF_OFS_IRQ_STATUS: rd_word[`TACF_EV_COUNT-1:0] = irq_status;
      `TACF_OFS_IRQ_MASK: rd_word[`TACF_EV_COUNT-1:0] = irq_mask;
      `TACF_OFS_LINK_STATE: begin
        rd_word[`TACF_LINK_MEMBER_BIT] = member_of_ring_status;
        rd_word[`TACF_LINK_PEND_BIT] = cmd_pend;
        rd_word[`TACF_LINK_CAUSE_LSB +: 3] = last_cause;
      end
      default: rd_word = 32'h0000_0000;
    endcase
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = mapped(s_axi_araddr) ? `TACF_RESP_OKAY : `TACF_RESP_SLVERR;
    end
  end

  // ====================================================================
  // Received bytes: addressed rescan commands and responses from peers.
  assign rescan_hit = rx_scb_valid && rx_scb_is_command && rx_node_addressed
    && rx_scb_byte[`TACF_SCB_RESCAN_BIT];
  assign resp_rx = rx_scb_valid && !rx_scb_is_command;

  // Control registers, next node address and received status.
  always_comb begin
    next_join = join_ring_request_ctl;
    next_own = own_node_address;
    next_next_addr = next_node_address;
    next_frame_status = frame_status_byte;
    next_last_cause = last_cause;
    if (wr_byte0 && word_of(wr_addr) == `TACF_OFS_CTRL) begin
      next_join = wr_data[`TACF_CTRL_JOIN_BIT];
    end
    if (wr_byte0 && word_of(wr_addr) == `TACF_OFS_OWN_ADDR) begin
      next_own = wr_data[7:0];
    end
    if (rescan_hit) begin
      next_next_addr = 8'(own_node_address + 8'h01); // [RL1]
    end
    if (resp_rx) begin
      // Reserved bits 5 to 3 are dropped here.
      next_frame_status = {rx_scb_byte[`TACF_SCB_WANTS_BIT],
        rx_scb_byte[`TACF_SCB_CAUSE_MSB:0]}; // [RL3] [RL7]
    end
    if (rx_frame_done && tacf_pkg::tacf_cause_legal(rx_frame_outcome)) begin
      next_last_cause = rx_frame_outcome; // [RL4] [RL5]
    end
  end

  // ====================================================================
  // Transmit slot: a pending response goes before a pending host command.
  assign load_resp = (tx_state == tacf_pkg::TACF_TX_IDLE) && resp_pend;
  assign load_cmd = (tx_state == tacf_pkg::TACF_TX_IDLE) && !resp_pend && cmd_pend;

  // Builds the response from live state, or the command from the host byte.
  tacf_scb_build u_build (
    .rescan(load_cmd && cmd_byte[`TACF_SCB_RESCAN_BIT]),
    .wants(load_cmd ? cmd_byte[`TACF_SCB_WANTS_BIT]
      : (join_ring_request_ctl && member_of_ring_status)), // [RL2]
    .cause(load_cmd ? cmd_byte[`TACF_SCB_CAUSE_MSB:0] : last_cause), // [RL4]
    .scb_byte(build_byte)
  );

  // Next state of the pending flags and the transmit slot.
  always_comb begin
    next_cmd_byte = cmd_byte;
    next_cmd_pend = cmd_pend && !load_cmd;
    // A request arriving while the previous response loads is kept.
    next_resp_pend = (resp_pend && !load_resp) || ack_request; // [RL6]
    if (wr_byte0 && word_of(wr_addr) == `TACF_OFS_CMD && !cmd_pend) begin
      next_cmd_byte = wr_data[7:0];
      next_cmd_pend = 1'b1; // [RL6]
    end
    next_tx_state = tx_state;
    next_tx_byte = tx_scb_byte;
    next_tx_is_cmd = tx_scb_is_command;
    case (tx_state)
      tacf_pkg::TACF_TX_IDLE: begin
        if (load_resp || load_cmd) begin
          next_tx_state = tacf_pkg::TACF_TX_BUSY;
          next_tx_byte = build_byte;
          next_tx_is_cmd = load_cmd;
        end
      end
      tacf_pkg::TACF_TX_BUSY: begin
        if (tx_scb_ready) begin
          next_tx_state = tacf_pkg::TACF_TX_IDLE;
        end
      end
      default: next_tx_state = tacf_pkg::TACF_TX_IDLE;
    endcase
  end

  assign tx_scb_valid = (tx_state == tacf_pkg::TACF_TX_BUSY);
  assign events = {tx_scb_valid && tx_scb_ready && tx_scb_is_command, resp_rx, rescan_hit};

  // ====================================================================
  // Interrupt status and mask.
  tacf_irq #(.EVENTS(`TACF_EV_COUNT)) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_pulse(events),
    .clear_wr(wr_byte0 && word_of(wr_addr) == `TACF_OFS_IRQ_STATUS),
    .mask_wr(wr_byte0 && word_of(wr_addr) == `TACF_OFS_IRQ_MASK),
    .wr_data(wr_data[`TACF_EV_COUNT-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ====================================================================
  // State registers of the block, except the interrupt status and mask held in tacf_irq.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TACF_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TACF_RESP_OKAY;
      join_ring_request_ctl <= 1'b0;
      own_node_address <= `TACF_OWN_ADDR_RST;
      next_node_address <= `TACF_NEXT_ADDR_RST;
      frame_status_byte <= 4'h0;
      last_cause <= 3'(tacf_pkg::TACF_CAUSE_OK);
      cmd_byte <= 8'h00;
      cmd_pend <= 1'b0;
      resp_pend <= 1'b0;
      tx_state <= tacf_pkg::TACF_TX_IDLE;
      tx_scb_byte <= 8'h00;
      tx_scb_is_command <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr_q <= next_aw_addr_q;
      w_data_q <= next_w_data_q;
      w_lane0_q <= next_w_lane0_q;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      join_ring_request_ctl <= next_join;
      own_node_address <= next_own;
      next_node_address <= next_next_addr;
      frame_status_byte <= next_frame_status;
      last_cause <= next_last_cause;
      cmd_byte <= next_cmd_byte;
      cmd_pend <= next_cmd_pend;
      resp_pend <= next_resp_pend;
      tx_state <= next_tx_state;
      tx_scb_byte <= next_tx_byte;
      tx_scb_is_command <= next_tx_is_cmd;
    end
  end

  // ====================================================================
  // Assertions.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A response byte is offered on the cycle after it was loaded.
  sequence s_resp_offer;
    !tx_scb_valid ##1 (tx_scb_valid && !tx_scb_is_command);
  endsequence

  chk_rescan_reload: assert property (rescan_hit |=> // [RL1]
    next_node_address == 8'($past(own_node_address) + 8'h01))
    else $error("next node address not reloaded after rescan");
  chk_wants_bit: assert property (s_resp_offer |-> // [RL2]
    tx_scb_byte[6] == ($past(join_ring_request_ctl) && $past(member_of_ring_status)))
    else $error("response wants bit wrong");
  chk_resp_passive: assert property (resp_rx && !rescan_hit |=> // [RL3]
    $stable(next_node_address) && frame_status_byte[3] == $past(rx_scb_byte[6]))
    else $error("received response misreported or acted on");
  chk_cause_field: assert property (s_resp_offer |-> // [RL4]
    tx_scb_byte[2:0] == $past(last_cause))
    else $error("response cause code wrong");
  chk_cause_legal: assert property (tacf_pkg::tacf_cause_legal(last_cause)) // [RL5]
    else $error("stored cause code undefined");
  chk_tx_source: assert property ($rose(tx_scb_valid) |-> // [RL6]
    (tx_scb_is_command ? $past(cmd_pend) : $past(resp_pend)))
    else $error("byte sent without command or request");
  chk_rsvd_zero: assert property (tx_scb_valid |-> tx_scb_byte[5:3] == 3'h0) // [RL7]
    else $error("reserved bits sent nonzero");
  chk_tx_hold: assert property (tx_scb_valid && !tx_scb_ready |=> // [RL6]
    tx_scb_valid && $stable(tx_scb_byte) && $stable(tx_scb_is_command))
    else $error("transmit byte dropped before accepted");

endmodule : tacf_top

// ===== tb/tacf_peer.sv
// Peer node model on the far side of the access-control field block's link.
// Assumes the bench calls its tasks and sets how many cycles it stalls before ready.
`timescale 1ns/100ps

module tacf_peer (
  input wire logic aclk,
  input wire logic [3:0] stall,
  output logic rx_scb_valid = 1'b0,
  output logic [7:0] rx_scb_byte = 8'h00,
  output logic rx_scb_is_command = 1'b0,
  output logic rx_node_addressed = 1'b0,
  output logic ack_request = 1'b0,
  input wire logic tx_scb_valid,
  output logic tx_scb_ready = 1'b0,
  input wire logic [7:0] tx_scb_byte,
  input wire logic tx_scb_is_command,
  output logic [7:0] got_byte = 8'h00,
  output logic got_cmd = 1'b0,
  output int got_count = 0
);
  int wait_cnt = 0;

  // ==========
  // Link stimulus.
  // Sends one byte for one cycle; a response keeps its outcome code in bits 2:0.
  // The released byte and addressed lines show the inverse so a stale value is never mistaken for a fresh one.
  task automatic send(input logic [7:0] b, input logic cmd, input logic adr);
    @(posedge aclk);
    rx_scb_valid <= 1'b1;
    rx_scb_byte <= b;
    rx_scb_is_command <= cmd;
    rx_node_addressed <= adr;
    @(posedge aclk);
    rx_scb_valid <= 1'b0;
    rx_scb_byte <= ~b;
    rx_node_addressed <= ~adr;
  endtask : send

  // Asks the block for an acknowledge with a one-cycle pulse.
  task automatic req_ack();
    @(posedge aclk);
    ack_request <= 1'b1;
    @(posedge aclk);
    ack_request <= 1'b0;
  endtask : req_ack

  // ==========
  // Receive side.
  // Takes an offered byte after the chosen stall, so both prompt and slow answers occur.
  always @(posedge aclk) begin
    if (tx_scb_valid && tx_scb_ready) begin
      got_byte <= tx_scb_byte;
      got_cmd <= tx_scb_is_command;
      got_count <= got_count + 1;
      tx_scb_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (tx_scb_valid) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= int'(stall)) begin
        tx_scb_ready <= 1'b1;
      end
    end
  end
endmodule : tacf_peer

// ===== tb/tb.sv
// Self-checking bench of the access-control field block with a peer node model.
// Assumes the design files and the peer model are compiled before it.
`timescale 1ns/100ps
`include "tacf_map.svh"

module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic rx_frame_done = 1'b0;
  logic [2:0] rx_frame_outcome = 3'h0;
  logic member_of_ring_status = 1'b0;
  logic [3:0] stall = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rx_scb_valid, rx_scb_is_command, rx_node_addressed, ack_request;
  logic [7:0] rx_scb_byte, tx_scb_byte, next_node_address, got_byte, b, own;
  logic tx_scb_valid, tx_scb_ready, tx_scb_is_command, irq, got_cmd, j, m;
  logic [7:0] lfsr = 8'h42;
  int got_count, i;
  int tx_total = 0;
  int err_count = 0;
  int cmp_count = 0;

  // ==========
  // Clock, design and peer.
  always #12.5 aclk = ~aclk;

  tacf_top tacf_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_scb_valid, .rx_scb_byte,
    .rx_scb_is_command, .rx_node_addressed, .rx_frame_done, .rx_frame_outcome,
    .ack_request, .member_of_ring_status, .tx_scb_valid, .tx_scb_ready, .tx_scb_byte,
    .tx_scb_is_command, .next_node_address, .irq);

  tacf_peer tacf_peer_i (.aclk, .stall, .rx_scb_valid, .rx_scb_byte, .rx_scb_is_command,
    .rx_node_addressed, .ack_request, .tx_scb_valid, .tx_scb_ready, .tx_scb_byte,
    .tx_scb_is_command, .got_byte, .got_cmd, .got_count);

  // ==========
  // Expectations and random source.
  function automatic logic [7:0] exp_resp(input logic jn, input logic mb, input logic [2:0] c);
    return {1'b0, jn & mb, 3'b000, c};
  endfunction : exp_resp

  // Steps the shift register and returns its new state.
  function logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd

  // ==========
  // Checking and closing.
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report(input bit hung);
    if (hung) err_count++;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // ==========
  // Bus and link tasks.
  // Offers address and data together and releases each once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 40) final_report(1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  // Reads one word and compares data and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 40) final_report(1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd

  // Reports the outcome of a finished frame.
  task automatic frame(input logic [2:0] c);
    @(posedge aclk);
    rx_frame_done <= 1'b1;
    rx_frame_outcome <= c;
    @(posedge aclk);
    rx_frame_done <= 1'b0;
    rx_frame_outcome <= ~c;
  endtask : frame

  // Waits for the peer to take the next byte and compares it.
  task automatic get_tx(input logic [7:0] want, input logic cmd);
    int n;
    tx_total++;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (got_count == tx_total) break;
    end
    if (n == 60) final_report(1'b1);
    chk({24'h0, got_byte}, {24'h0, want});
    chk({31'h0, got_cmd}, {31'h0, cmd});
  endtask : get_tx

  // ==========
  // Main sequence.
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`TACF_OFS_NEXT_ADDR, 32'h0, `TACF_RESP_OKAY);
    rd(8'h20, 32'h0, `TACF_RESP_SLVERR);
    wr(8'h24, 32'h1, `TACF_RESP_SLVERR);
    // Rescan from several own addresses, the wrap at ff first; ignored bytes between.
    for (i = 0; i < 6; i++) begin
      own = (i == 0) ? 8'hff : rnd();
      wr(`TACF_OFS_OWN_ADDR, {24'h0, own}, `TACF_RESP_OKAY);
      tacf_peer_i.send(rnd() | 8'h80, 1'b1, 1'b1);
      @(negedge aclk);
      chk({24'h0, next_node_address}, {24'h0, own + 8'h01});
      wr(`TACF_OFS_OWN_ADDR, {24'h0, ~own}, `TACF_RESP_OKAY);
      tacf_peer_i.send(rnd() & 8'h7f, 1'b1, 1'b1);
      tacf_peer_i.send(rnd() | 8'h80, 1'b1, 1'b0);
      tacf_peer_i.send(rnd() | 8'h80, 1'b0, 1'b1);
      @(negedge aclk);
      chk({24'h0, next_node_address}, {24'h0, own + 8'h01});
      rd(`TACF_OFS_NEXT_ADDR, {24'h0, own + 8'h01}, `TACF_RESP_OKAY);
    end
    // A write with lane 0 off changes nothing but is still answered.
    s_axi_wstrb <= 4'h0;
    wr(`TACF_OFS_OWN_ADDR, 32'h5a, `TACF_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`TACF_OFS_OWN_ADDR, {24'h0, ~own}, `TACF_RESP_OKAY);
    // Received responses reach the frame status with reserved bits dropped.
    for (i = 0; i < 6; i++) begin
      b = rnd();
      tacf_peer_i.send(b, 1'b0, b[0]);
      rd(`TACF_OFS_FRAME_STATUS, {28'h0, b[6], b[2:0]}, `TACF_RESP_OKAY);
    end
    // Every outcome code under every join and membership setting.
    for (i = 0; i < 20; i++) begin
      j = i[0];
      m = i[1];
      b = rnd();
      stall <= {1'b0, b[2:0]};
      frame(3'(i / 4));
      wr(`TACF_OFS_CTRL, {31'h0, j}, `TACF_RESP_OKAY);
      member_of_ring_status <= m;
      rd(`TACF_OFS_LINK_STATE, {25'h0, 3'(i / 4), 3'b000, m}, `TACF_RESP_OKAY);
      tacf_peer_i.req_ack();
      get_tx(exp_resp(j, m, 3'(i / 4)), 1'b0);
    end
    frame(3'h5);
    frame(3'h7);
    tacf_peer_i.req_ack();
    get_tx(exp_resp(1'b1, 1'b1, 3'h4), 1'b0);
    // Host commands against a slow peer.
    stall <= 4'hf;
    for (i = 0; i < 4; i++) begin
      b = rnd();
      wr(`TACF_OFS_CMD, {24'h0, b}, `TACF_RESP_OKAY);
      get_tx(b & 8'hc7, 1'b1);
    end
    // Interrupt: events set status, the mask gates the line, a written one clears.
    stall <= 4'h0;
    wr(`TACF_OFS_IRQ_MASK, 32'h0, `TACF_RESP_OKAY);
    wr(`TACF_OFS_IRQ_STATUS, 32'h7, `TACF_RESP_OKAY);
    tacf_peer_i.send(8'h80, 1'b1, 1'b1);
    tacf_peer_i.send(8'h41, 1'b0, 1'b1);
    wr(`TACF_OFS_CMD, 32'h12, `TACF_RESP_OKAY);
    get_tx(8'h02, 1'b1);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(`TACF_OFS_IRQ_STATUS, 32'h7, `TACF_RESP_OKAY);
    wr(`TACF_OFS_IRQ_MASK, 32'h2, `TACF_RESP_OKAY);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(`TACF_OFS_IRQ_MASK, 32'h2, `TACF_RESP_OKAY);
    rd(`TACF_OFS_CMD, 32'h12, `TACF_RESP_OKAY);
    wr(`TACF_OFS_IRQ_STATUS, 32'h2, `TACF_RESP_OKAY);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(`TACF_OFS_IRQ_STATUS, 32'h5, `TACF_RESP_OKAY);
    final_report(1'b0);
  end
endmodule : tb
